//--- core/ast_tx.sv
// asynchronous serial transmitter with register port, baud divider and pin takeover
//
// The plain strobed port and the register offsets were left to the implementer.
`include "ast_regs.svh"

// Contract
// - idle line held high mark
// - start, eight or nine data, stop
// - start low, stop high
// - each bit held one bit period
// - baud divider with 8/16-bit divisor
// - data shifted LSB first
// - transmit independent, shared format and rate
// - no hardware parity, ninth bit software
// - enabled when transmit_enable_bit, sync clear, serial_port_enable
// - serial_port_enable forces transmit pin to output
// - serial_port_enable forces receive pin input, readable
// - buffer-empty flag set when transmit_enable_bit sets
// - buffer write starts, immediate load if idle
// - queued char loads after stop, one cycle
// - flag clear only busy with queued char; code also holds it clear while transmit_enable_bit is clear
// - flag valid from second cycle after write
// - buffer-empty flag is read-only
// - interrupt only when enable set
// - shifter-empty set idle, cleared on load
// - no interrupt from shifter-empty
// - shifter not mapped to software
// - nine-bit mode sends ninth bit as MSB
module ast_tx (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupt request
    output logic tx_irq,
    // transmit clock pin
    output logic txck_o,
    output logic txck_oe_n,
    // receive data pin
    input wire logic rxdt_i,
    output logic rxdt_o,
    output logic rxdt_oe_n
);

    ast_pkg::ast_state_t state_q;
    logic [7:0] ctrl_q;
    logic [7:0] brg_lo_q;
    logic [7:0] brg_hi_q;
    logic [7:0] irq_en_q;
    logic [7:0] buf_q;
    logic buf_full_q;
    logic [8:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [15:0] baud_cnt_q;
    logic baud_tick;
    logic flag_q;
    logic transmit_enable_bit_q;
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_dir_q;
    logic rx_lat_q;
    logic txck_q;
    logic tx_active;
    logic buf_wr;
    logic load;
    logic shifter_empty;
    logic [3:0] nbits;

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    assign tx_active = ctrl_q[`AST_CTRL_TRANSMIT_ENABLE_BIT] && !ctrl_q[`AST_CTRL_SYNC]
                       && ctrl_q[`AST_CTRL_SERIAL_PORT_ENABLE];
    assign buf_wr = reg_wr && (reg_addr == `AST_OFF_BUF);
    assign shifter_empty = (state_q == ast_pkg::AST_IDLE);
    // 1 start + data + 1 stop; parity only via software ninth bit
    assign nbits = ctrl_q[`AST_CTRL_NINE] ? 4'h9 : 4'h8;
    // idle shifter takes the char at once
    // waiting for a later tick would let a second write overwrite the first char
    assign load = tx_active && buf_full_q && shifter_empty;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `AST_CTRL_RESET;
            brg_lo_q <= 8'h00;
            brg_hi_q <= 8'h00;
            irq_en_q <= `AST_IRQ_RESET;
            rx_dir_q <= 1'b1;
            rx_lat_q <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `AST_OFF_CTRL: begin
                    // shifter-empty stays hardware-owned
                    ctrl_q <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
                end
                `AST_OFF_BRG_LO: begin
                    brg_lo_q <= reg_wdata;
                end
                `AST_OFF_BRG_HI: begin
                    brg_hi_q <= reg_wdata;
                end
                `AST_OFF_IRQ_EN: begin
                    irq_en_q <= reg_wdata;
                end
                `AST_OFF_PINS: begin
                    rx_dir_q <= reg_wdata[`AST_PIN_RXDIR];
                    rx_lat_q <= reg_wdata[`AST_PIN_RXLAT];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            buf_q <= 8'h00;
            buf_full_q <= 1'b0;
        end else if (buf_wr) begin
            // a write during load overwrites the handed-off slot again
            buf_q <= reg_wdata;
            buf_full_q <= 1'b1;
        end else if (load || !ctrl_q[`AST_CTRL_TRANSMIT_ENABLE_BIT]) begin
            buf_full_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // baud timing
    // ----------------------------------------------------------------
    // divisor of 8 or 16 bits, bit period = (n+1) cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            baud_cnt_q <= 16'h0000;
        end else if (shifter_empty) begin
            baud_cnt_q <= 16'h0000;
        end else if (baud_tick) begin
            baud_cnt_q <= 16'h0000;
        end else begin
            baud_cnt_q <= baud_cnt_q + 16'h0001;
        end
    end
    assign baud_tick = ctrl_q[`AST_CTRL_BRG16] ? (baud_cnt_q == {brg_hi_q, brg_lo_q})
                                               : (baud_cnt_q == {8'h00, brg_lo_q});

    // ----------------------------------------------------------------
    // shifter state machine
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ast_pkg::AST_IDLE;
            shift_q <= 9'h1FF;
            bit_cnt_q <= 4'h0;
        end else if (!tx_active) begin
            // disabling aborts the frame, line returns to mark
            state_q <= ast_pkg::AST_IDLE;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ast_pkg::AST_IDLE: begin
                    if (load) begin
                        shift_q <= {ctrl_q[`AST_CTRL_NINTH], buf_q};
                        state_q <= ast_pkg::AST_START;
                    end
                end
                ast_pkg::AST_START: begin
                    if (baud_tick) begin
                        state_q <= ast_pkg::AST_DATA;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ast_pkg::AST_DATA: begin
                    if (baud_tick) begin
                        shift_q <= {1'b1, shift_q[8:1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == nbits - 4'h1) begin
                            state_q <= ast_pkg::AST_STOP;
                        end
                    end
                end
                ast_pkg::AST_STOP: begin
                    if (baud_tick) begin
                        // queued char loads on the very next cycle
                        state_q <= ast_pkg::AST_IDLE;
                    end
                end
                default: begin
                    state_q <= ast_pkg::AST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // line level
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txck_q <= 1'b1;
        end else begin
            case (state_q)
                ast_pkg::AST_START: begin
                    txck_q <= 1'b0;
                end
                ast_pkg::AST_DATA: begin
                    txck_q <= shift_q[0];
                end
                default: begin
                    txck_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // buffer-empty flag and interrupt
    // ----------------------------------------------------------------
    // forced low after a write, then follows the buffer; settled by the second cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            transmit_enable_bit_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            transmit_enable_bit_q <= ctrl_q[`AST_CTRL_TRANSMIT_ENABLE_BIT];
            if (ctrl_q[`AST_CTRL_TRANSMIT_ENABLE_BIT] && !transmit_enable_bit_q) begin
                flag_q <= 1'b1;
            end else if (buf_wr) begin
                flag_q <= 1'b0;
            end else begin
                flag_q <= ctrl_q[`AST_CTRL_TRANSMIT_ENABLE_BIT] && !buf_full_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_irq <= 1'b0;
        end else begin
            // shifter-empty never reaches here
            tx_irq <= flag_q && irq_en_q[`AST_IRQ_TXBIT];
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rxdt_i;
            rx_sync_q <= rx_meta_q;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txck_o <= 1'b1;
            txck_oe_n <= 1'b1;
            rxdt_o <= 1'b0;
            rxdt_oe_n <= 1'b1;
        end else begin
            txck_o <= txck_q;
            txck_oe_n <= !ctrl_q[`AST_CTRL_SERIAL_PORT_ENABLE];
            rxdt_o <= rx_lat_q;
            // port latch blocked while the serial unit owns the pin
            rxdt_oe_n <= ctrl_q[`AST_CTRL_SERIAL_PORT_ENABLE] || rx_dir_q;
        end
    end

    // ----------------------------------------------------------------
    // read back; shifter itself has no address
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `AST_OFF_CTRL: begin
                    reg_rdata <= {ctrl_q[7:2], shifter_empty, ctrl_q[0]};
                end
                `AST_OFF_BRG_LO: begin
                    reg_rdata <= brg_lo_q;
                end
                `AST_OFF_BRG_HI: begin
                    reg_rdata <= brg_hi_q;
                end
                `AST_OFF_IRQ_EN: begin
                    reg_rdata <= irq_en_q;
                end
                `AST_OFF_IRQ_FLG: begin
                    reg_rdata <= {6'h00, flag_q, 1'b0};
                end
                `AST_OFF_PINS: begin
                    reg_rdata <= {5'h00, rx_lat_q, rx_dir_q, rx_sync_q};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

//--- pkg/ast_pkg.sv
// types shared by the serial transmitter
package ast_pkg;
    typedef enum logic [3:0] {
        AST_IDLE = 4'h1,
        AST_START = 4'h2,
        AST_DATA = 4'h4,
        AST_STOP = 4'h8
    } ast_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ast_bus_req_t;

    typedef struct packed {
        logic o;
        logic oe_n;
    } ast_pin_drv_t;
endpackage

//--- pkg/ast_regs.svh
// register offsets, field positions, reset values and timing counts of the transmitter
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AST_OFF_CTRL 4'h0
`define AST_OFF_BUF 4'h1
`define AST_OFF_BRG_LO 4'h2
`define AST_OFF_BRG_HI 4'h3
`define AST_OFF_IRQ_EN 4'h4
`define AST_OFF_IRQ_FLG 4'h5
`define AST_OFF_PINS 4'h6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define AST_CTRL_NINTH 0
`define AST_CTRL_SHEMPTY 1
`define AST_CTRL_SYNC 4
`define AST_CTRL_TRANSMIT_ENABLE_BIT 5
`define AST_CTRL_NINE 6
`define AST_CTRL_SERIAL_PORT_ENABLE 7
`define AST_CTRL_BRG16 3
`define AST_CTRL_RESET 8'h02

// ----------------------------------------------------------------
// interrupt flag and enable position, pin register fields
// ----------------------------------------------------------------
`define AST_IRQ_TXBIT 1
`define AST_IRQ_RESET 8'h00
`define AST_PIN_RXLVL 0
`define AST_PIN_RXDIR 1
`define AST_PIN_RXLAT 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AST_TCY_CLKS 4
`define AST_FLAG_VALID_TCY 2

`endif

//--- test/ast_rx_model.sv
// remote receiver that samples the serial line at mid-bit
module ast_rx_model #(parameter int BIT = 4) (
    input wire logic mclk,
    input wire logic line,
    input wire logic nine,
    output int cnt,
    output int ferr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] q [8];
    int gap [8];
    int hi;
    // sampling on the falling edge keeps clear of the line's launch edge
    initial begin
        cnt = 0;
        ferr = 0;
        hi = 0;
        forever begin
            @(negedge mclk);
            if (line) begin
                hi++;
            end else begin
                gap[cnt] = hi;
                q[cnt] = 9'h000;
                repeat (BIT / 2) @(negedge mclk);
                if (line !== 1'b0) ferr++;
                for (int i = 0; i < (nine ? 9 : 8); i++) begin
                    repeat (BIT) @(negedge mclk);
                    q[cnt][i] = line;
                end
                repeat (BIT) @(negedge mclk);
                if (line !== 1'b1) ferr++;
                hi = BIT / 2;
                cnt++;
            end
        end
    end
endmodule

//--- test/ast_tx_properties.sv
// port-level assertions for the serial transmitter
module ast_tx_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // interrupt and pins
    input wire logic tx_irq,
    input wire logic txck_o,
    input wire logic txck_oe_n,
    input wire logic rxdt_i,
    input wire logic rxdt_o,
    input wire logic rxdt_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic serial_port_enable_q;
    logic en_q;
    logic ie_q;
    logic [3:0] hi_q;
    // ----------------------------------------------------------------
    // shadows decoded from bus writes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            serial_port_enable_q <= 1'b0;
            en_q <= 1'b0;
            ie_q <= 1'b0;
        end else if (reg_wr && reg_addr == 4'h0) begin
            serial_port_enable_q <= reg_wdata[7];
            en_q <= reg_wdata[7] & reg_wdata[5] & ~reg_wdata[4];
        end else if (reg_wr && reg_addr == 4'h4) begin
            ie_q <= reg_wdata[1];
        end
    end
    // counts unbroken mark cycles up to 15; a run of 1 bits inside a frame counts as well as an idle line
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hi_q <= 4'h0;
        end else begin
            hi_q <= !txck_o ? 4'h0 : (hi_q == 4'hF ? hi_q : hi_q + 4'h1);
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    property p_low_width; $fell(txck_o) |-> !txck_o [*4]; endproperty
    a_low_width: assert property (p_low_width) else $error("space bit too short");
    property p_high_width; $rose(txck_o) |-> txck_o [*4]; endproperty
    a_high_width: assert property (p_high_width) else $error("mark bit too short");
    property p_idle_off; !en_q && $past(!en_q) && $past(!en_q, 2) && $past(!en_q, 3) |-> txck_o; endproperty
    a_idle_off: assert property (p_idle_off) else $error("line left mark while off");
    property p_pins_on; serial_port_enable_q && $past(serial_port_enable_q) |-> !txck_oe_n && rxdt_oe_n; endproperty
    a_pins_on: assert property (p_pins_on) else $error("pins not taken over");
    property p_pins_off; !serial_port_enable_q && $past(!serial_port_enable_q) |-> txck_oe_n; endproperty
    a_pins_off: assert property (p_pins_off) else $error("line driven while port off");
    property p_start; reg_wr && reg_addr == 4'h1 && en_q && hi_q >= 4'hC |-> ##[2:6] !txck_o; endproperty
    a_start: assert property (p_start) else $error("no start after write");
    property p_irq_mask; !ie_q && $past(!ie_q) |-> !tx_irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_irq_en; $rose(en_q) && ie_q |-> ##[1:8] tx_irq; endproperty
    a_irq_en: assert property (p_irq_en) else $error("no irq on enable");
    property p_rdata; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
    a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule

bind ast_tx ast_tx_properties u_props (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_irq(tx_irq),
    .txck_o(txck_o), .txck_oe_n(txck_oe_n), .rxdt_i(rxdt_i), .rxdt_o(rxdt_o), .rxdt_oe_n(rxdt_oe_n));

//--- test/tb.sv
// self-checking bench for the serial transmitter
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, reg_wr, reg_rd, rxdt_i, nine;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic tx_irq, txck_o, txck_oe_n, rxdt_o, rxdt_oe_n;
    int cnt, ferr, error_cnt, n_tests;
    ast_tx u_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_irq(tx_irq), .txck_o(txck_o),
        .txck_oe_n(txck_oe_n), .rxdt_i(rxdt_i), .rxdt_o(rxdt_o), .rxdt_oe_n(rxdt_oe_n));
    // divisor 3 gives four clocks a bit
    ast_rx_model #(.BIT(4)) u_rx (.mclk(mclk), .line(txck_o), .nine(nine), .cnt(cnt), .ferr(ferr));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic complete_run();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), 16'(reg_rdata), 16'(e));
    endtask
    task automatic wait_rx(int n);
        int t = 0;
        while (cnt < n && t < 2000) begin
            @(posedge mclk);
            t++;
        end
        chk("frames", 16'(cnt), 16'(n));
    endtask
    initial begin
        #50us;
        error_cnt++;
        complete_run();
    end
    initial begin
        error_cnt = 0;
        n_tests = 0;
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        rxdt_i = 1'b1;
        nine = 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd(4'h0, 8'h02);
        rd(4'h4, 8'h00);
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h03);
        rd(4'h1, 8'h00);
        rd(4'h7, 8'h00);
        wr(4'h2, 8'h03);
        wr(4'h6, 8'h04);
        repeat (2) @(posedge mclk);
        chk("rx_drive", 16'({rxdt_oe_n, rxdt_o}), 16'h1);
        wr(4'h4, 8'h02);
        wr(4'h0, 8'hA2);
        repeat (12) @(posedge mclk);
        chk("irq_on", 16'(tx_irq), 16'h1);
        chk("pins_on", 16'({txck_oe_n, rxdt_oe_n}), 16'h1);
        rd(4'h6, 8'h05);
        rd(4'h5, 8'h02);
        wr(4'h5, 8'h00);
        rd(4'h5, 8'h02);
        // second char queues behind the first
        wr(4'h1, 8'hA5);
        wr(4'h1, 8'h3C);
        repeat (8) @(posedge mclk);
        rd(4'h5, 8'h00);
        chk("irq_queued", 16'(tx_irq), 16'h0);
        rd(4'h0, 8'hA0);
        wait_rx(2);
        chk("char0", 16'(u_rx.q[0]), 16'h0A5);
        chk("char1", 16'(u_rx.q[1]), 16'h03C);
        chk("gap1", 16'(u_rx.gap[1] <= 8), 16'h1);
        repeat (12) @(posedge mclk);
        rd(4'h0, 8'hA2);
        wr(4'h4, 8'h00);
        repeat (4) @(posedge mclk);
        chk("irq_off", 16'(tx_irq), 16'h0);
        nine <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(4'h0, 8'hE0 | 8'(k));
            wr(4'h1, 8'h5A ^ 8'(k));
            wait_rx(3 + k);
            chk("char9", 16'(u_rx.q[2 + k]), 16'({1'(k), 8'h5A ^ 8'(k)}));
        end
        chk("ferr", 16'(ferr), 16'h0);
        repeat (12) @(posedge mclk);
        // sync mode, then port off: nothing may leave
        wr(4'h0, 8'hB0);
        wr(4'h1, 8'hFF);
        repeat (60) @(posedge mclk);
        wr(4'h0, 8'h20);
        wr(4'h1, 8'hFF);
        repeat (60) @(posedge mclk);
        chk("frames_off", 16'(cnt), 16'h4);
        chk("pins_off", 16'({txck_oe_n, rxdt_oe_n}), 16'h2);
        rxdt_i <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(4'h6, 8'h04);
        complete_run();
    end
endmodule
